// >>> rtl/adc_port.sv
// Serial host port of a sigma-delta converter with checksum protection
`timescale 1ns/10ps
`include "adc_port_defines.svh"
module adc_port import adc_port_pkg::*; #(
   parameter int BUF_DEPTH = 2
) (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        din,
   output logic             dout,
   output logic             dout_oe,
   input  wire logic        word_valid,
   input  wire logic [23:0] word_data,
   output logic             word_ready,
   input  wire logic [1:0]  chk_mode,
   input  wire logic        cont_read,
   input  wire logic        hold_out,
   input  wire logic [15:0] reg_rdata,
   output logic             rdy_n,
   output logic             crc_err,
   output logic             wr_stb,
   output logic [5:0]       wr_addr,
   output logic [23:0]      wr_data,
   output logic             port_rst
);

   // ****************************************
   // Timing
   // ****************************************
   // Output release delay, rounded up to whole cycles, never below one
   localparam int hold_raw = (`HOLD_NS * `CLK_MHZ + 999) / 1000;
   localparam int hold_cyc = (hold_raw < 1) ? 1 : hold_raw;
   localparam int hold_max = hold_cyc + 1;

   if (hold_cyc > 15 || BUF_DEPTH < 2) begin : g_bad
      $error("adc_port: hold count or buffer depth out of range");
   end

   // ****************************************
   // State
   // ****************************************
   port_s       s;
   port_s       n;
   logic        rise;
   logic        fall;
   logic        sel;
   logic        pop;
   logic        buf_valid;
   logic [23:0] buf_data;
   logic        chk_on;
   logic        data_busy;
   logic [7:0]  cmd_nx;
   logic [7:0]  stat_b;
   logic [31:0] rd_word;

   // ****************************************
   // Checksum and register length helpers
   // ****************************************
   // One message bit into the CRC remainder; zero start makes this the
   // remainder of the message shifted left by eight bits
   function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
      crc_bit = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `CRC_POLY : 8'h00);
   endfunction : crc_bit

   function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] v);
      logic [7:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = crc_bit(r, v[i]);
      end
      crc_byte = r;
   endfunction : crc_byte

   function automatic logic [7:0] xor_bit(input logic [7:0] x, input logic b,
                                          input logic [2:0] idx);
      xor_bit = x ^ (b ? (8'h80 >> idx) : 8'h00);
   endfunction : xor_bit

   function automatic logic [4:0] reg_last(input logic [5:0] a);
      if (a == `ADDR_DATA) begin
         reg_last = `DATA_LAST;
      end else if (a == `ADDR_STATUS) begin
         reg_last = `STAT_LAST;
      end else begin
         reg_last = `OTHER_LAST;
      end
   endfunction : reg_last

   // ****************************************
   // Word buffer
   // ****************************************
   // Two words of slack so a result arriving mid-read is kept, not dropped
   pair_buffer #(
      .W     (24),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .in_valid  (word_valid),
      .in_data   (word_data),
      .in_ready  (word_ready),
      .out_valid (buf_valid),
      .out_data  (buf_data),
      .out_ready (pop)
   );

   // ****************************************
   // Decode
   // ****************************************
   assign rise      = s.ck_s & ~s.ck_p;
   assign fall      = ~s.ck_s & s.ck_p;
   assign sel       = ~s.cs_s;
   assign chk_on    = (chk_mode != `CHK_OFF);                                         // [RQ15]
   assign rdy_n     = ~s.fresh | s.upd;                                               // [RQ4]
   assign data_busy = ((s.st == ST_RD) || (s.st == ST_RCHK)) && (s.cmd[5:0] == `ADDR_DATA);
   assign cmd_nx    = {s.cmd[6:0], s.di_s};
   assign stat_b    = ({7'h00, rdy_n} << `STAT_RDY_BIT)                               // [RQ9]
                    | ({7'h00, s.crc_err} << `STAT_CRCERR_BIT);

   always_comb begin
      if (cmd_nx[5:0] == `ADDR_DATA) begin
         // A word loading in this very cycle is the one the host reads
         rd_word = {s.upd ? buf_data : s.data, 8'h00};                                // [RQ6]
      end else if (cmd_nx[5:0] == `ADDR_STATUS) begin
         rd_word = {stat_b, 24'h000000};
      end else begin
         rd_word = {reg_rdata, 16'h0000};
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic       done_rd;
      logic       done_wr;
      logic       to_cmd;
      logic [7:0] nc;
      logic [7:0] nx;
      done_rd = 1'b0;
      done_wr = 1'b0;
      to_cmd  = 1'b0;
      nc      = 8'h00;
      nx      = 8'h00;
      n       = s;
      pop     = 1'b0;
      n.ck_m  = sclk;                                                                 // [RQ1]
      n.ck_s  = s.ck_m;
      n.ck_p  = s.ck_s;
      n.cs_m  = cs_n;
      n.cs_s  = s.cs_m;
      n.di_m  = din;
      n.di_s  = s.di_m;
      n.wr_stb   = 1'b0;
      n.port_rst = 1'b0;

      // Raise ready for one cycle before the data register changes
      if (s.upd) begin
         n.upd   = 1'b0;
         n.data  = buf_data;
         n.fresh = 1'b1;
         pop     = 1'b1;
      end else if (buf_valid && !data_busy && !(s.st == ST_CMD && (rise || fall))) begin
         // No update on a link edge in command wait: a data read may start there
         n.upd = 1'b1;                                                                // [RQ4]
      end

      if (s.cs_s) begin
         n.rst_cnt = '0;
      end else if (rise) begin
         n.rst_cnt = s.di_s ? s.rst_cnt + 7'h01 : 7'h00;                              // [RQ10]
      end

      case (s.st)
         ST_CMD: begin
            if (rise) begin
               n.cmd   = cmd_nx;                                                      // [RQ25]
               n.acc_c = crc_bit(s.acc_c, s.di_s);
               n.acc_x = xor_bit(s.acc_x, s.di_s, s.cnt[2:0]);
               n.cnt   = s.cnt + 5'h01;
               if (s.cnt == `BYTE_LAST) begin                                         // [RQ8]
                  n.cnt = '0;
                  n.sh  = '0;
                  // An all-ones byte is not a command, so a reset run stays idle
                  if (cmd_nx[`CMD_WEN_BIT]) begin
                     to_cmd = 1'b1;
                  end else if (cmd_nx[`CMD_RD_BIT]) begin
                     n.st = ST_RD;
                     n.sh = rd_word;
                  end else begin
                     n.st = ST_WR;
                  end
               end
            end else if (fall && s.cnt == '0 && cont_read && s.fresh && !s.upd) begin
               n.st    = ST_RD;                                                       // [RQ7]
               n.cmd   = `CONT_CMD;
               n.acc_c = crc_byte(8'h00, `CONT_CMD);                                  // [RQ19]
               n.acc_x = `CONT_CMD;
               n.dout  = s.data[23];
               n.sh    = {s.data[22:0], 9'h000};
            end
         end
         ST_WR: begin
            if (rise) begin
               n.sh    = {s.sh[30:0], s.di_s};
               n.acc_c = crc_bit(s.acc_c, s.di_s);                                    // [RQ14]
               n.cnt   = s.cnt + 5'h01;
               if (s.cnt == reg_last(s.cmd[5:0])) begin
                  n.cnt = '0;
                  if (chk_on) begin
                     n.st    = ST_WCHK;                                               // [RQ16]
                     n.acc_x = '0;
                  end else begin
                     done_wr = 1'b1;
                  end
               end
            end
         end
         ST_WCHK: begin
            if (rise) begin
               n.acc_x = {s.acc_x[6:0], s.di_s};
               n.cnt   = s.cnt + 5'h01;
               if (s.cnt == `BYTE_LAST) begin
                  if ({s.acc_x[6:0], s.di_s} != s.acc_c) begin
                     n.crc_err = 1'b1;                                                // [RQ12]
                     to_cmd    = 1'b1;
                  end else begin
                     done_wr = 1'b1;
                  end
               end
            end
         end
         ST_RD: begin
            if (fall) begin
               n.dout = s.sh[31];                                                     // [RQ25]
               n.sh   = {s.sh[30:0], 1'b0};
            end
            if (rise) begin
               nc      = crc_bit(s.acc_c, s.dout);                                    // [RQ18]
               nx      = xor_bit(s.acc_x, s.dout, s.cnt[2:0]);                        // [RQ21]
               n.acc_c = nc;
               n.acc_x = nx;
               n.cnt   = s.cnt + 5'h01;
               if (s.cnt == reg_last(s.cmd[5:0])) begin
                  n.cnt = '0;
                  if (chk_on) begin
                     n.st = ST_RCHK;                                                  // [RQ16]
                     n.sh = {(chk_mode == `CHK_XOR) ? nx : nc, 24'h000000};           // [RQ20]
                  end else begin
                     done_rd = 1'b1;
                  end
               end
            end
         end
         ST_RCHK: begin
            if (fall) begin
               n.dout = s.sh[31];
               n.sh   = {s.sh[30:0], 1'b0};
            end
            if (rise) begin
               n.cnt = s.cnt + 5'h01;
               if (s.cnt == `BYTE_LAST) begin
                  done_rd = 1'b1;
               end
            end
         end
         ST_HOLD: begin
            if (!hold_out) begin
               if (s.hold <= 4'h1) begin
                  to_cmd = 1'b1;                                                      // [RQ23]
               end else begin
                  n.hold = s.hold - 4'h1;
               end
            end
         end
         default: begin
            to_cmd = 1'b1;
         end
      endcase

      if (done_rd) begin
         n.st   = ST_HOLD;
         n.hold = 4'(hold_cyc);
         if (s.cmd[5:0] == `ADDR_DATA) begin
            n.fresh = 1'b0;                                                           // [RQ3]
         end
         if (s.cmd[5:0] == `ADDR_STATUS) begin
            n.crc_err = 1'b0;                                                         // [RQ24]
         end
      end
      if (done_wr) begin
         to_cmd = 1'b1;
         // Status and data are read-only; their writes are dropped
         if (s.cmd[5:0] != `ADDR_STATUS && s.cmd[5:0] != `ADDR_DATA) begin
            n.wr_stb  = 1'b1;
            n.wr_addr = s.cmd[5:0];
            n.wr_data = n.sh[23:0];
         end
      end
      if (to_cmd || s.cs_s) begin
         n.st    = ST_CMD;                                                            // [RQ22]
         n.cnt   = '0;
         n.acc_c = '0;
         n.acc_x = '0;
      end
      if (sel && rise && s.di_s && s.rst_cnt == `RST_LAST) begin
         n.st       = ST_CMD;                                                         // [RQ10]
         n.cnt      = '0;
         n.acc_c    = '0;
         n.acc_x    = '0;
         n.rst_cnt  = '0;
         n.fresh    = 1'b0;
         n.upd      = 1'b0;
         n.crc_err  = 1'b0;
         n.data     = '0;
         n.wr_stb   = 1'b0;
         n.port_rst = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s <= PORT_RST;
      end else begin
         s <= n;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Combinational mux of flops: a registered pin would eat the half period
   assign dout     = ((s.st == ST_RD) || (s.st == ST_RCHK) || (s.st == ST_HOLD))
                   ? s.dout : rdy_n;                                                  // [RQ2]
   assign dout_oe  = sel;                                                             // [RQ22]
   assign crc_err  = s.crc_err;
   assign wr_stb   = s.wr_stb;
   assign wr_addr  = s.wr_addr;
   assign wr_data  = s.wr_data;
   assign port_rst = s.port_rst;

   // ****************************************
   // Checks
   // ****************************************
   chk_update_order: assert property (@(posedge ref_clk) disable iff (!nrst)  // [RQ4]
      $rose(s.fresh) |-> $past(s.upd) && $past(rdy_n))
      else $error("data register loaded without ready raised first");

   chk_ready_low: assert property (@(posedge ref_clk) disable iff (!nrst)     // [RQ2]
      (s.st == ST_CMD && sel && s.fresh && !s.upd) |-> (!dout && dout_oe))
      else $error("ready not shown low on shared output");

   chk_read_done: assert property (@(posedge ref_clk) disable iff (!nrst)     // [RQ3]
      (data_busy && n.st == ST_HOLD && !s.upd) |=> !s.fresh ##1 rdy_n)
      else $error("ready not released after data read");

   chk_reset_run: assert property (@(posedge ref_clk) disable iff (!nrst)     // [RQ10]
      (sel && rise && s.di_s && s.rst_cnt == `RST_LAST)
      |=> (s.port_rst && s.st == ST_CMD && !s.fresh && !s.crc_err))
      else $error("serial reset run not honoured");

   chk_crc_flag: assert property (@(posedge ref_clk) disable iff (!nrst)      // [RQ12]
      (s.st == ST_WCHK && rise && s.cnt == `BYTE_LAST && !s.cs_s
       && {s.acc_x[6:0], s.di_s} != s.acc_c) |=> (s.crc_err && !s.wr_stb))
      else $error("checksum mismatch not flagged");

   chk_flag_clear: assert property (@(posedge ref_clk) disable iff (!nrst)    // [RQ24]
      $fell(s.crc_err) |-> ($past(s.cmd[5:0]) == `ADDR_STATUS) || s.port_rst)
      else $error("checksum error cleared without status read");

   chk_deselect: assert property (@(posedge ref_clk) disable iff (!nrst)      // [RQ22]
      s.cs_s |-> (!dout_oe ##1 (s.st == ST_CMD)))
      else $error("port active while deselected");

   chk_write_check: assert property (@(posedge ref_clk) disable iff (!nrst)   // [RQ16]
      (s.wr_stb && chk_on) |-> ($past(s.st) == ST_WCHK))
      else $error("protected write committed without checksum");

   chk_hold_release: assert property (@(posedge ref_clk) disable iff (!nrst)  // [RQ23]
      (s.st == ST_HOLD && !hold_out && !s.cs_s) |-> ##[1:hold_max] (s.st != ST_HOLD))
      else $error("output not returned to ready in time");

endmodule : adc_port

// >>> include/adc_port_defines.svh
// Constants of the converter serial host port
//
// Contract
// [RQ1] Four lines: select low, serial in, host serial clock, shared serial out.
// [RQ2] Shared output goes low for ready when a fresh word waits and select is low.
// [RQ3] Ready returns high once a data register read has finished.
// [RQ4] Ready goes high before a new result is written into the data register.
// [RQ5] Host reads as soon as ready falls and finishes before the next result.
// [RQ6] Outside continuous read the data register may be read again until updated.
// [RQ7] In continuous read each result is sent only once.
// [RQ8] Three-wire use with select tied low also works.
// [RQ9] Ready is also visible as a bit of the status register.
// [RQ10] 64 clocks with select low and input high reset port and registers.
// [RQ11] Host waits 500 us after the serial reset before the next transaction.
// [RQ12] A write whose checksum mismatches sets the checksum error flag.
// [RQ13] Host reads a protected register back and checks its checksum.
// [RQ14] Write checksums always use the CRC polynomial x^8 + x^2 + x + 1.
// [RQ15] A mode field turns checksums off, or picks CRC or XOR for reads.
// [RQ16] When enabled an 8-bit checksum ends every read and write.
// [RQ17] Host computes write checksum over command byte then 8 to 24 data bits.
// [RQ18] Read checksum covers command byte then 8 to 32 output bits. The code sends at most 24 output bits.
// [RQ19] Continuous read checksum includes an implied command byte 0x44 first.
// [RQ20] CRC is the remainder of message times x^8 divided by the polynomial.
// [RQ21] XOR checksum combines all message bytes by bitwise exclusive-or.
// [RQ22] The port answers only while its select is low.
// [RQ23] Output returns to ready after a short delay, or at select high if held.
// [RQ24] Checksum error flag stays set until a status register read clears it.
// [RQ25] Bytes and words travel most significant bit first both ways.
`ifndef ADC_PORT_DEFINES_SVH
`define ADC_PORT_DEFINES_SVH

// ****************************************
// Command byte and addresses
// ****************************************
`define CMD_WEN_BIT      7
`define CMD_RD_BIT       6
`define ADDR_STATUS      6'h00
`define ADDR_DATA        6'h04
`define CONT_CMD         8'h44

// ****************************************
// Register widths as last bit index; status bit positions
// ****************************************
`define DATA_LAST        5'h17
`define STAT_LAST        5'h07
`define OTHER_LAST       5'h0F
`define STAT_RDY_BIT     7
`define STAT_CRCERR_BIT  6

// ****************************************
// Checksum
// ****************************************
`define CRC_POLY         8'h07
`define CHK_OFF          2'h0
`define CHK_XOR          2'h1
`define BYTE_LAST        5'h07

// ****************************************
// Serial reset and timing
// ****************************************
`define RST_LAST         7'h3F
`define CLK_MHZ          25
`define HOLD_NS          40

`endif

// >>> include/adc_port_pkg.sv
// Types of the converter serial host port
package adc_port_pkg;

   typedef enum logic [2:0] {
      ST_CMD  = 3'b000,
      ST_WR   = 3'b001,
      ST_WCHK = 3'b010,
      ST_RD   = 3'b011,
      ST_RCHK = 3'b100,
      ST_HOLD = 3'b101
   } port_st_e;

   typedef struct packed {
      logic        cs_m;
      logic        cs_s;
      logic        ck_m;
      logic        ck_s;
      logic        ck_p;
      logic        di_m;
      logic        di_s;
      port_st_e    st;
      logic [4:0]  cnt;
      logic [7:0]  cmd;
      logic [7:0]  acc_c;
      logic [7:0]  acc_x;
      logic [31:0] sh;
      logic [6:0]  rst_cnt;
      logic [3:0]  hold;
      logic        dout;
      logic        fresh;
      logic        upd;
      logic        crc_err;
      logic        wr_stb;
      logic        port_rst;
      logic [5:0]  wr_addr;
      logic [23:0] data;
      logic [23:0] wr_data;
   } port_s;

   localparam port_s PORT_RST = '{cs_m: 1'b1, cs_s: 1'b1, ck_m: 1'b1, ck_s: 1'b1,
                                  ck_p: 1'b1, st: ST_CMD, default: '0};

endpackage : adc_port_pkg

// >>> rtl/pair_buffer.sv
// Small word buffer with valid and ready on both sides
`timescale 1ns/10ps
module pair_buffer #(
   parameter int W     = 24,
   parameter int DEPTH = 2
) (
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || W < 1) begin : g_bad
      $error("pair_buffer needs DEPTH of 2 or more");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
   } buf_s;

   buf_s s;
   buf_s n;
   logic push;
   logic pull;

   function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
      wrap = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : wrap

   assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s.cnt != '0);
   assign out_data  = s.mem[s.rp];
   assign push      = in_valid & in_ready;
   assign pull      = out_valid & out_ready;

   always_comb begin
      n = s;
      if (push) begin
         n.mem[s.wp] = in_data;
         n.wp        = wrap(s.wp);
      end
      if (pull) begin
         n.rp = wrap(s.rp);
      end
      case ({push, pull})
         2'b10:   n.cnt = s.cnt + (AW+1)'(1);
         2'b01:   n.cnt = s.cnt - (AW+1)'(1);
         default: n.cnt = s.cnt;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

endmodule : pair_buffer

// >>> tb/host_model.sv
// Host side serial bus master model
`timescale 1ns/10ps
module host_model (
   input  wire logic ref_clk,
   output logic      cs_n,
   output logic      sclk,
   output logic      din,
   input  wire logic dout,
   input  wire logic dout_oe
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din  = 1'b1;
   end
   // Clock stands high outside frames; nine system cycles per bit
   task automatic xfer(input int n, input logic [31:0] w, output logic [31:0] r);
      r = '0;
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge ref_clk) sclk = 1'b0;
         din = w[i]; // Most significant bit first
         repeat (4) @(negedge ref_clk);
         r = {r[30:0], (dout_oe ? dout : ~dout)};
         sclk = 1'b1;
         repeat (4) @(negedge ref_clk);
      end
   endtask : xfer
   task automatic sel(input logic s);
      @(negedge ref_clk) cs_n = s; // Select frames one or more transfers
      if (s) din = ~din; // Released line no longer shows its last value
      repeat (4) @(negedge ref_clk);
   endtask : sel
endmodule : host_model

// >>> tb/adc_port_bench.sv
// Self-checking bench of the converter serial host port
`timescale 1ns/10ps
module adc_port_bench;
   logic        ref_clk = 1'b0, nrst;
   logic        cs_n, sclk, din, dout, dout_oe;
   logic        word_valid, word_ready, cont_read, hold_out;
   logic [23:0] word_data, wr_data;
   logic [1:0]  chk_mode;
   logic [15:0] reg_rdata;
   logic        rdy_n, crc_err, wr_stb, port_rst;
   logic [5:0]  wr_addr;
   logic [31:0] r, c;
   int          error_cnt = 0, tests_run = 0, cyc = 0, stb_cnt = 0, rst_cnt = 0;
   always #20 ref_clk = ~ref_clk;
   host_model h (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
                 .dout_oe(dout_oe));
   adc_port dut_u (.ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .din(din),
      .dout(dout), .dout_oe(dout_oe), .word_valid(word_valid), .word_data(word_data),
      .word_ready(word_ready), .chk_mode(chk_mode), .cont_read(cont_read),
      .hold_out(hold_out), .reg_rdata(reg_rdata), .rdy_n(rdy_n), .crc_err(crc_err),
      .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .port_rst(port_rst));
   // Strobes last one cycle, so they are counted where they stand
   always @(posedge ref_clk) begin
      stb_cnt <= stb_cnt + int'(wr_stb);
      rst_cnt <= rst_cnt + int'(port_rst);
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         $display("unexpected at %0t: run too long", $time);
         end_sim();
      end
   end
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] crc8(input logic [39:0] m, input int n);
      logic [7:0] k;
      k = 8'h00;
      for (int i = n - 1; i >= 0; i--) k = {k[6:0], 1'b0} ^ ((k[7] ^ m[i]) ? 8'h07 : 8'h00);
      return k;
   endfunction : crc8
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic push(input logic [23:0] w);
      @(negedge ref_clk) word_data = w;
      word_valid = 1'b1;
      for (int k = 0; k < 20 && word_ready !== 1'b1; k++) @(negedge ref_clk);
      @(negedge ref_clk) word_valid = 1'b0;
      h.sel(1'b0);
      for (int k = 0; k < 50 && dout !== 1'b0; k++) @(negedge ref_clk);
   endtask : push
   task automatic end_sim;
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_data;
      push(24'hA5C30F);
      chk(dout, 1'b0, "ready low");
      chk(word_ready, 1'b1, "buffer drained");
      for (int n = 0; n < 2; n++) begin
         h.xfer(8, 32'h44, r);
         h.xfer(24, 0, r);
         chk(r, 32'hA5C30F, "data word");
         repeat (4) @(negedge ref_clk);
         chk(rdy_n, 1'b1, "ready after read");
      end
      h.xfer(8, 32'h40, r);
      h.xfer(8, 0, r);
      chk(r[7], 1'b1, "status ready bit");
      h.sel(1'b1);
      $display("done data read");
   endtask : t_data
   task automatic t_rdchk;
      for (int m = 1; m < 3; m++) begin
         chk_mode = m[1:0];
         hold_out = (m == 2);
         h.sel(1'b0);
         h.xfer(8, 32'h65, r);
         h.xfer(16, 0, r);
         h.xfer(8, 0, c);
         repeat (8) @(negedge ref_clk);
         chk(dout, (m == 2) ? 1'b0 : 1'b1, "output after read");
         h.sel(1'b1);
         chk(r, 32'h4321, "register read");
         chk(c, (m == 1) ? 32'h07 : 32'h86, "read checksum");
      end
      hold_out = 1'b0;
      $display("done read checksum");
   endtask : t_rdchk
   task automatic t_write;
      chk_mode = 2'h2;
      for (int b = 0; b < 2; b++) begin
         h.sel(1'b0);
         h.xfer(24, 32'h104321, r);
         h.xfer(8, crc8(40'h104321, 24) ^ b[7:0], r);
         h.sel(1'b1);
         chk(stb_cnt, 1, "write strobes");
         chk({wr_addr, wr_data}, {6'h10, 24'h004321}, "write");
         chk(crc_err, b[0], "error flag");
      end
      // Outside register file returns what was written
      reg_rdata = wr_data[15:0];
      h.sel(1'b0);
      h.xfer(8, 32'h50, r);
      h.xfer(16, 0, r);
      h.xfer(8, 0, c);
      h.sel(1'b1);
      chk(r, 32'h4321, "read back");
      chk(c, crc8(40'h504321, 24), "read back checksum");
      chk_mode = 2'h0;
      h.sel(1'b0);
      h.xfer(16, 32'h4000, r);
      h.sel(1'b1);
      chk(r[6], 1'b1, "status error bit");
      chk(crc_err, 1'b0, "flag cleared");
      $display("done write");
   endtask : t_write
   task automatic t_cont;
      chk_mode = 2'h2;
      cont_read = 1'b1;
      push(24'h000000);
      h.xfer(24, 0, r);
      h.xfer(8, 0, c);
      repeat (4) @(negedge ref_clk);
      chk(dout, 1'b1, "word sent once");
      h.sel(1'b1);
      chk(r, 32'h0, "continuous word");
      chk(c, crc8(40'h44000000, 32), "implied command");
      cont_read = 1'b0;
      $display("done continuous read");
   endtask : t_cont
   task automatic t_reset;
      chk_mode = 2'h0;
      // An unread word must be dropped by the serial reset
      push(24'h123456);
      h.xfer(32, 32'hFFFFFFFF, r);
      h.xfer(32, 32'hFFFFFFFF, r);
      h.sel(1'b1);
      chk(rst_cnt, 1, "serial reset");
      repeat (12500) @(negedge ref_clk); // Quiet time of 500 us
      h.sel(1'b0);
      h.xfer(16, 32'h4000, r);
      h.sel(1'b1);
      chk(r[7:0], 8'h80, "status after reset");
      $display("done serial reset");
   endtask : t_reset
   initial begin
      nrst       = 1'b0;
      word_valid = 1'b0;
      word_data  = '0;
      cont_read  = 1'b0;
      hold_out   = 1'b0;
      chk_mode   = 2'h0;
      reg_rdata  = 16'h4321;
      repeat (6) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (4) @(negedge ref_clk);
      t_data();
      t_rdchk();
      t_write();
      t_cont();
      t_reset();
      end_sim();
   end
endmodule : adc_port_bench
